// ===== core/ldr_defs.svh
// Constants for the regulator control register bank.
`ifndef LDR_DEFS_SVH
`define LDR_DEFS_SVH

// ==========================================================================
// Register indices; the byte address of each is four times its index.
`define LDR_IDX_A_CTRL    8'h59
`define LDR_IDX_B_VSEL    8'h60
`define LDR_IDX_B_CTRL    8'h61
`define LDR_IDX_C_VSEL    8'h68
`define LDR_IDX_C_CTRL    8'h69
`define LDR_IDX_D_VSEL    8'h70
`define LDR_IDX_D_CTRL    8'h71
`define LDR_IDX_E_VSEL    8'h80
`define LDR_IDX_NONE      8'h00

// ==========================================================================
// Field positions inside the byte-wide registers.
`define LDR_VCODE_MSB     5
`define LDR_VCODE_LSB     0
`define LDR_EN_BIT        7
`define LDR_DIS_BIT       2
`define LDR_FIE_BIT       1
`define LDR_PG_BIT        0

// ==========================================================================
// Reset values of the writable fields.
`define LDR_RST_VCODE     6'h00
`define LDR_RST_EN        1'h0
`define LDR_RST_DIS       1'h0
`define LDR_RST_FIE       1'h0

// ==========================================================================
// Bus geometry and responses.
`define LDR_ADDR_W        12
`define LDR_NUM_CHAN      5
`define LDR_RESP_OKAY     2'h0
`define LDR_RESP_DECERR   2'h3

`endif

// ===== core/ldr_pkg.sv
// Types shared by the regulator control register bank.
`include "ldr_defs.svh"
package ldr_pkg;

   // ========================================================================
   // Write and read channel states, one-hot.
   typedef enum logic [1:0] {
      LDR_W_COLLECT = 2'h1,
      LDR_W_RESP    = 2'h2
   } ldr_wr_state_t;

   typedef enum logic [1:0] {
      LDR_R_IDLE = 2'h1,
      LDR_R_DATA = 2'h2
   } ldr_rd_state_t;

   // ========================================================================
   // State of one regulator channel.
   typedef struct packed {
      logic [5:0] vcode;
      logic       en;
      logic       dis;
      logic       fie;
      logic       pg_meta;
      logic       pg_sync;
      logic       dis_on;
   } ldr_chan_t;

   // ========================================================================
   // State of the bus slave.
   typedef struct packed {
      ldr_wr_state_t            wst;
      ldr_rd_state_t            rdst;
      logic                     awready;
      logic                     wready;
      logic                     arready;
      logic                     aw_held;
      logic                     w_held;
      logic [`LDR_ADDR_W-1:0]   awaddr;
      logic [7:0]               wdata;
      logic                     wlane0;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     rvalid;
      logic [31:0]              rdata;
      logic [1:0]               rresp;
   } ldr_axi_t;

endpackage

// ===== core/ldr_chan.sv
// One regulator channel: voltage code, control bits and power-good sync.
`timescale 1ns/100ps
`include "ldr_defs.svh"
module ldr_chan #(
   parameter bit HAS_VSEL = 1'b1,
   parameter bit HAS_CTRL = 1'b1
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        vsel_we,
   input  wire logic        ctrl_we,
   input  wire logic [7:0]  wdata,
   input  wire logic        pgood_pin,
   output logic      [7:0]  vsel_rd,
   output logic      [7:0]  ctrl_rd,
   output logic      [5:0]  voltage_code,
   output logic             enable,
   output logic             discharge_en,
   output logic             fault_ie,
   output logic             discharge_active
);

   ldr_pkg::ldr_chan_t st_ff;
   ldr_pkg::ldr_chan_t nxt_st;

   // ========================================================================
   // Next state: register writes, power-good synchroniser, discharge drive.
   always_comb begin
      nxt_st = st_ff;
      if (HAS_VSEL && vsel_we) begin
         nxt_st.vcode = wdata[`LDR_VCODE_MSB:`LDR_VCODE_LSB]; // RULE_01
      end
      if (HAS_CTRL && ctrl_we) begin
         nxt_st.en  = wdata[`LDR_EN_BIT];  // RULE_02
         nxt_st.dis = wdata[`LDR_DIS_BIT]; // RULE_03
         nxt_st.fie = wdata[`LDR_FIE_BIT]; // RULE_04
      end
      nxt_st.pg_meta = pgood_pin;
      nxt_st.pg_sync = st_ff.pg_meta;
      // Discharge only while switched off and discharge is allowed.
      nxt_st.dis_on = nxt_st.dis & ~nxt_st.en; // RULE_03
   end

   // Registers the channel state; synchronous active-low reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '{vcode: `LDR_RST_VCODE, en: `LDR_RST_EN,
                    dis: `LDR_RST_DIS, fie: `LDR_RST_FIE,
                    pg_meta: 1'h0, pg_sync: 1'h0, dis_on: 1'h0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ========================================================================
   // Read views; reserved bits are constant zero and ignore writes.
   always_comb begin
      vsel_rd = 8'h00;
      ctrl_rd = 8'h00;
      if (HAS_VSEL) begin
         vsel_rd[`LDR_VCODE_MSB:`LDR_VCODE_LSB] = st_ff.vcode; // RULE_06
      end
      if (HAS_CTRL) begin
         ctrl_rd[`LDR_EN_BIT]  = st_ff.en;
         ctrl_rd[`LDR_DIS_BIT] = st_ff.dis;
         ctrl_rd[`LDR_FIE_BIT] = st_ff.fie;
         ctrl_rd[`LDR_PG_BIT]  = st_ff.pg_sync; // RULE_05
      end
   end

   // Outputs to the analog regulator, each straight from a flip-flop.
   assign voltage_code     = st_ff.vcode;
   assign enable           = st_ff.en;
   assign discharge_en     = st_ff.dis;
   assign fault_ie         = st_ff.fie;
   assign discharge_active = st_ff.dis_on;

   // ========================================================================
   // Checks on the channel.
   AST_VCODE_WRITE: assert property ( // RULE_01
      @(posedge aclk) disable iff (!aresetn)
      (HAS_VSEL && vsel_we) |=> (voltage_code == $past(wdata[5:0])))
      else $error("Voltage code did not take the written value.");

   AST_ENABLE_WRITE: assert property ( // RULE_02
      @(posedge aclk) disable iff (!aresetn)
      (HAS_CTRL && ctrl_we) |=> (enable == $past(wdata[7])))
      else $error("Enable did not take the written value.");

   AST_DISCHARGE: assert property ( // RULE_03
      @(posedge aclk) disable iff (!aresetn)
      (HAS_CTRL && ctrl_we) |=>
         (discharge_active == ($past(wdata[2]) && !$past(wdata[7]))))
      else $error("Discharge drive disagrees with the control bits.");

   AST_FAULT_WRITE: assert property ( // RULE_04
      @(posedge aclk) disable iff (!aresetn)
      (HAS_CTRL && ctrl_we) |=>
         (fault_ie == $past(wdata[1]) && discharge_en == $past(wdata[2])))
      else $error("Fault or discharge bit did not take the written value.");

   AST_FAULT_ENABLE: assert property ( // RULE_04
      @(posedge aclk) disable iff (!aresetn)
      (!ctrl_we && !vsel_we) |=> ($stable(fault_ie) && $stable(enable)))
      else $error("Control bit changed without a write.");

   AST_PGOOD: assert property ( // RULE_05
      @(posedge aclk) disable iff (!aresetn)
      (HAS_CTRL && $past(aresetn) && $past(aresetn, 2)) |->
         (ctrl_rd[0] == $past(pgood_pin, 2)))
      else $error("Power-good read does not follow the input.");

   AST_RESERVED: assert property ( // RULE_06
      @(posedge aclk) disable iff (!aresetn)
      (vsel_rd[7:6] == 2'h0) && (ctrl_rd[6:3] == 4'h0))
      else $error("Reserved bit reads as one.");

endmodule

// ===== core/ldr_regs.sv
// AXI4-Lite register bank for five linear regulators.
//
// Contract
// [RULE_01] Voltage register holds a read/write 6-bit output code in bits 5:0.
// [RULE_02] Control bit 7 is read/write enable: 1 turns regulator on, 0 off.
// [RULE_03] Control bit 2 enables output discharge while shut down.
// [RULE_04] Control bit 1 lets regulator faults raise interrupts when set.
// [RULE_05] Control bit 0 is read-only power-good, 1 above threshold.
// [RULE_06] Reserved bits are read-only, ignore writes and read as zero.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ldr_defs.svh"
module ldr_regs (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [`LDR_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]               s_axi_awprot,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic      [1:0]               s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`LDR_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]               s_axi_arprot,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic      [31:0]              s_axi_rdata,
   output logic      [1:0]               s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic [4:0]               power_good_in,
   output logic      [29:0]              output_voltage_code,
   output logic      [4:0]               regulator_enable,
   output logic      [4:0]               shutdown_discharge_enable,
   output logic      [4:0]               fault_interrupt_enable,
   output logic      [4:0]               discharge_active
);

   // ========================================================================
   // Channel map: index 0 is regulator A through index 4 for regulator E.
   localparam logic [4:0] HAS_V = 5'h1E;
   localparam logic [4:0] HAS_C = 5'h0F;
   localparam logic [7:0] IDX_V [`LDR_NUM_CHAN] = '{
      `LDR_IDX_NONE, `LDR_IDX_B_VSEL, `LDR_IDX_C_VSEL,
      `LDR_IDX_D_VSEL, `LDR_IDX_E_VSEL};
   localparam logic [7:0] IDX_C [`LDR_NUM_CHAN] = '{
      `LDR_IDX_A_CTRL, `LDR_IDX_B_CTRL, `LDR_IDX_C_CTRL,
      `LDR_IDX_D_CTRL, `LDR_IDX_NONE};

   ldr_pkg::ldr_axi_t st_ff;
   ldr_pkg::ldr_axi_t nxt_st;

   logic [7:0] vsel_rd [`LDR_NUM_CHAN];
   logic [7:0] ctrl_rd [`LDR_NUM_CHAN];
   logic [4:0] vsel_we;
   logic [4:0] ctrl_we;
   logic       do_write;
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] rd_byte;

   // Byte address of a register from its index; only aligned words match.
   function automatic logic reg_hit(
      input logic [`LDR_ADDR_W-1:0] addr,
      input logic [7:0]             idx
   );
      reg_hit = (addr == {2'h0, idx, 2'h0});
   endfunction

   // ========================================================================
   // Write decode: a write with byte lane 0 strobed is applied once both address and data are held.
   always_comb begin
      do_write = (st_ff.wst == ldr_pkg::LDR_W_COLLECT) &&
                 st_ff.aw_held && st_ff.w_held;
      wr_hit   = 1'b0;
      vsel_we  = 5'h00;
      ctrl_we  = 5'h00;
      for (int i = 0; i < `LDR_NUM_CHAN; i++) begin
         if (HAS_V[i] && reg_hit(st_ff.awaddr, IDX_V[i])) begin
            wr_hit     = 1'b1;
            vsel_we[i] = do_write && st_ff.wlane0; // RULE_01
         end else if (HAS_C[i] && reg_hit(st_ff.awaddr, IDX_C[i])) begin
            wr_hit     = 1'b1;
            ctrl_we[i] = do_write && st_ff.wlane0; // RULE_02
         end
      end
   end

   // Read decode straight from the offered read address.
   always_comb begin
      rd_hit  = 1'b0;
      rd_byte = 8'h00;
      for (int i = 0; i < `LDR_NUM_CHAN; i++) begin
         if (HAS_V[i] && reg_hit(s_axi_araddr, IDX_V[i])) begin
            rd_hit  = 1'b1;
            rd_byte = vsel_rd[i];
         end else if (HAS_C[i] && reg_hit(s_axi_araddr, IDX_C[i])) begin
            rd_hit  = 1'b1;
            rd_byte = ctrl_rd[i]; // RULE_05
         end
      end
   end

   // ========================================================================
   // Next state of the write channel: address and data may come in any order.
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.wst)
         ldr_pkg::LDR_W_COLLECT: begin
            if (s_axi_awvalid && st_ff.awready) begin
               nxt_st.aw_held = 1'b1;
               nxt_st.awready = 1'b0;
               nxt_st.awaddr  = s_axi_awaddr;
            end
            if (s_axi_wvalid && st_ff.wready) begin
               nxt_st.w_held = 1'b1;
               nxt_st.wready = 1'b0;
               nxt_st.wdata  = s_axi_wdata[7:0];
               nxt_st.wlane0 = s_axi_wstrb[0];
            end
            if (do_write) begin
               nxt_st.bvalid = 1'b1;
               nxt_st.bresp  = wr_hit ? `LDR_RESP_OKAY : `LDR_RESP_DECERR;
               nxt_st.wst    = ldr_pkg::LDR_W_RESP;
            end
         end
         ldr_pkg::LDR_W_RESP: begin
            if (s_axi_bready) begin
               nxt_st.bvalid  = 1'b0;
               nxt_st.aw_held = 1'b0;
               nxt_st.w_held  = 1'b0;
               nxt_st.awready = 1'b1;
               nxt_st.wready  = 1'b1;
               nxt_st.wst     = ldr_pkg::LDR_W_COLLECT;
            end
         end
         default: begin
            nxt_st.wst = ldr_pkg::LDR_W_COLLECT;
         end
      endcase

      // Read channel: one cycle from address taken to data valid.
      case (st_ff.rdst)
         ldr_pkg::LDR_R_IDLE: begin
            if (s_axi_arvalid) begin
               nxt_st.arready = 1'b0;
               nxt_st.rvalid  = 1'b1;
               nxt_st.rdata   = {24'h000000, rd_byte}; // RULE_06
               nxt_st.rresp   = rd_hit ? `LDR_RESP_OKAY : `LDR_RESP_DECERR;
               nxt_st.rdst    = ldr_pkg::LDR_R_DATA;
            end
         end
         ldr_pkg::LDR_R_DATA: begin
            if (s_axi_rready) begin
               nxt_st.rvalid  = 1'b0;
               nxt_st.arready = 1'b1;
               nxt_st.rdst    = ldr_pkg::LDR_R_IDLE;
            end
         end
         default: begin
            nxt_st.rdst = ldr_pkg::LDR_R_IDLE;
         end
      endcase
   end

   // Registers the slave state; ready outputs come up high after reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '{wst: ldr_pkg::LDR_W_COLLECT, rdst: ldr_pkg::LDR_R_IDLE,
                    awready: 1'b1, wready: 1'b1, arready: 1'b1,
                    aw_held: 1'b0, w_held: 1'b0, awaddr: '0, wdata: 8'h00,
                    wlane0: 1'b0, bvalid: 1'b0, bresp: `LDR_RESP_OKAY,
                    rvalid: 1'b0, rdata: 32'h00000000,
                    rresp: `LDR_RESP_OKAY};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Bus outputs, each straight from a flip-flop.
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready  = st_ff.wready;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign s_axi_rdata   = st_ff.rdata;
   assign s_axi_rresp   = st_ff.rresp;

   // ========================================================================
   // One channel per regulator; absent registers are left out by parameter.
   for (genvar g = 0; g < `LDR_NUM_CHAN; g++) begin : g_chan
      ldr_chan #(
         .HAS_VSEL (HAS_V[g]),
         .HAS_CTRL (HAS_C[g])
      ) u_chan (
         .aclk             (aclk),
         .aresetn          (aresetn),
         .vsel_we          (vsel_we[g]),
         .ctrl_we          (ctrl_we[g]),
         .wdata            (st_ff.wdata),
         .pgood_pin        (power_good_in[g]),
         .vsel_rd          (vsel_rd[g]),
         .ctrl_rd          (ctrl_rd[g]),
         .voltage_code     (output_voltage_code[g*6 +: 6]),
         .enable           (regulator_enable[g]),
         .discharge_en     (shutdown_discharge_enable[g]),
         .fault_ie         (fault_interrupt_enable[g]),
         .discharge_active (discharge_active[g])
      );
   end

   // ========================================================================
   // Checks on the bus slave and the register views.
   AST_BVALID_HOLD: assert property ( // RULE_02
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
      else $error("Write response dropped before it was taken.");

   AST_WRITE_TO_RESP: assert property ( // RULE_01
      @(posedge aclk) disable iff (!aresetn)
      (vsel_we != 5'h00 || ctrl_we != 5'h00) |=>
         (s_axi_bvalid && s_axi_bresp == `LDR_RESP_OKAY))
      else $error("Register write not answered with OKAY.");

   AST_READ_LATENCY: assert property ( // RULE_05
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
      else $error("Read data not valid one cycle after the address.");

   AST_RDATA_UPPER: assert property ( // RULE_06
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h000000))
      else $error("Upper read data bits not zero.");

   AST_UNMAPPED_READ: assert property ( // RULE_06
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && !rd_hit) |=>
         (s_axi_rresp == `LDR_RESP_DECERR && s_axi_rdata == 32'h00000000))
      else $error("Unmapped read not answered with a decode error.");

   AST_WRITE_READY: assert property ( // RULE_02
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && s_axi_bready) |=>
         (!s_axi_bvalid && s_axi_awready && s_axi_wready))
      else $error("Write channel not ready again after the response.");

   AST_READ_READY: assert property ( // RULE_05
      @(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && s_axi_rready) |=> (!s_axi_rvalid && s_axi_arready))
      else $error("Read channel not ready again after the data.");

endmodule

// ===== tb/test_ldo_regulator_control_regs.sv
// Self-checking bench for the regulator control register bank.
`timescale 1ns/100ps
`include "ldr_defs.svh"
module test_ldo_regulator_control_regs;

   // =======================================================================
   // Signals, expectation queues and the register shadow.
   logic                   aclk;
   logic                   aresetn;
   logic [`LDR_ADDR_W-1:0] s_axi_awaddr;
   logic [`LDR_ADDR_W-1:0] s_axi_araddr;
   logic [2:0]             s_axi_awprot;
   logic [2:0]             s_axi_arprot;
   logic                   s_axi_awvalid;
   logic                   s_axi_awready;
   logic                   s_axi_wvalid;
   logic                   s_axi_wready;
   logic [31:0]            s_axi_wdata;
   logic [31:0]            s_axi_rdata;
   logic [3:0]             s_axi_wstrb;
   logic [1:0]             s_axi_bresp;
   logic [1:0]             s_axi_rresp;
   logic                   s_axi_bvalid;
   logic                   s_axi_bready;
   logic                   s_axi_arvalid;
   logic                   s_axi_arready;
   logic                   s_axi_rvalid;
   logic                   s_axi_rready;
   logic [4:0]             power_good_in;
   logic [4:0]             regulator_enable;
   logic [4:0]             shutdown_discharge_enable;
   logic [4:0]             fault_interrupt_enable;
   logic [4:0]             discharge_active;
   logic [29:0]            output_voltage_code;
   logic [1:0]             wr_q[$];
   logic [33:0]            rd_q[$];
   logic [5:0]             vsel_m[5];
   logic [7:0]             ctl_m[5];
   logic [7:0]             vsel_idx[5];
   logic [7:0]             ctl_idx[5];
   int                     fail_count;
   int                     n_checks;

   ldr_regs dut_u (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .s_axi_awaddr              (s_axi_awaddr),
      .s_axi_awprot              (s_axi_awprot),
      .s_axi_awvalid             (s_axi_awvalid),
      .s_axi_awready             (s_axi_awready),
      .s_axi_wdata               (s_axi_wdata),
      .s_axi_wstrb               (s_axi_wstrb),
      .s_axi_wvalid              (s_axi_wvalid),
      .s_axi_wready              (s_axi_wready),
      .s_axi_bresp               (s_axi_bresp),
      .s_axi_bvalid              (s_axi_bvalid),
      .s_axi_bready              (s_axi_bready),
      .s_axi_araddr              (s_axi_araddr),
      .s_axi_arprot              (s_axi_arprot),
      .s_axi_arvalid             (s_axi_arvalid),
      .s_axi_arready             (s_axi_arready),
      .s_axi_rdata               (s_axi_rdata),
      .s_axi_rresp               (s_axi_rresp),
      .s_axi_rvalid              (s_axi_rvalid),
      .s_axi_rready              (s_axi_rready),
      .power_good_in             (power_good_in),
      .output_voltage_code       (output_voltage_code),
      .regulator_enable          (regulator_enable),
      .shutdown_discharge_enable (shutdown_discharge_enable),
      .fault_interrupt_enable    (fault_interrupt_enable),
      .discharge_active          (discharge_active)
   );

   // =======================================================================
   // Clock, comparison and verdict.
   always #25 aclk = ~aclk;

   task automatic check(input string nm, input logic [33:0] seen,
                        input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // =======================================================================
   // Bus master tasks; each ready on the answer may be stalled a while.
   function automatic logic [11:0] ba(input logic [7:0] idx);
      ba = {2'h0, idx, 2'h0};
   endfunction

   task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                            input logic st, input logic [1:0] rsp);
      logic [31:0] r;
      int          n;
      int          dly;
      r = $urandom;
      dly = $urandom_range(2, 0);
      @(posedge aclk);
      wr_q.push_back(rsp);
      s_axi_awaddr  <= a;
      s_axi_awprot  <= r[2:0];
      s_axi_awvalid <= 1'h1;
      s_axi_wdata   <= {r[31:8], d};
      s_axi_wstrb   <= {r[7:5], st};
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= (dly == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (n == dly)
            s_axi_bready <= 1'h1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
      s_axi_bready <= 1'h0;
      if (n >= 40)
         fail_count++;
   endtask

   task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
      int n;
      int dly;
      dly = $urandom_range(2, 0);
      @(posedge aclk);
      rd_q.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arprot  <= 3'($urandom);
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= (dly == 0);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (n == dly)
            s_axi_rready <= 1'h1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
      s_axi_rready <= 1'h0;
      if (n >= 40)
         fail_count++;
   endtask

   // Monitor: every response taken is compared with the oldest note.
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         if (wr_q.size() == 0)
            check("bresp_unexpected", 34'h1, 34'h0);
         else
            check("bresp", 34'(s_axi_bresp), 34'(wr_q.pop_front()));
      end
      if (s_axi_rvalid && s_axi_rready) begin
         if (rd_q.size() == 0)
            check("rdata_unexpected", 34'h1, 34'h0);
         else
            check("rdata", {s_axi_rresp, s_axi_rdata},
                  rd_q.pop_front());
      end
   end

   // =======================================================================
   // Reset, and a full sweep of the outputs and every register.
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (vsel_m[g]) begin
         vsel_m[g] = 6'h00;
         ctl_m[g] = 8'h00;
      end
      repeat (3) @(posedge aclk);
   endtask

   task automatic chk_all();
      for (int g = 0; g < 5; g++) begin
         check("vcode", 34'(output_voltage_code[g*6+:6]),
               34'(vsel_m[g]));
         check("enable", 34'(regulator_enable[g]),
               34'(ctl_m[g][7]));
         check("dis", 34'(shutdown_discharge_enable[g]),
               34'(ctl_m[g][2]));
         check("dis_on", 34'(discharge_active[g]),
               34'(ctl_m[g][2] & ~ctl_m[g][7]));
         check("fie", 34'(fault_interrupt_enable[g]),
               34'(ctl_m[g][1]));
         // Missing registers of A and E answer with a decode error.
         axi_read(ba(vsel_idx[g]),
                  (g == 0) ? {`LDR_RESP_DECERR, 32'h0} :
                  {`LDR_RESP_OKAY, 26'h0, vsel_m[g]});
         axi_read(ba(ctl_idx[g]),
                  (g == 4) ? {`LDR_RESP_DECERR, 32'h0} :
                  {`LDR_RESP_OKAY, 24'h0, ctl_m[g][7:1],
                   power_good_in[g]});
      end
   endtask

   // =======================================================================
   // Main sequence.
   initial begin
      logic [7:0] d;
      logic       st;
      int         g;
      aclk = 1'h0;
      aresetn = 1'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      s_axi_awvalid = 1'h0;
      s_axi_wvalid = 1'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_bready = 1'h0;
      s_axi_arvalid = 1'h0;
      s_axi_rready = 1'h0;
      power_good_in = 5'h00;
      fail_count = 0;
      n_checks = 0;
      vsel_idx = '{8'h58, `LDR_IDX_B_VSEL, `LDR_IDX_C_VSEL,
                   `LDR_IDX_D_VSEL, `LDR_IDX_E_VSEL};
      ctl_idx = '{`LDR_IDX_A_CTRL, `LDR_IDX_B_CTRL, `LDR_IDX_C_CTRL,
                  `LDR_IDX_D_CTRL, 8'h81};
      void'($urandom(74607));
      do_reset();
      chk_all();
      // Every enable, discharge and fault-enable mix on channels A to D.
      for (int i = 0; i < 32; i++) begin
         g = i % 4;
         power_good_in <= 5'($urandom);
         d = 8'($urandom);
         d[7] = i[4];
         d[2] = i[3];
         d[1] = i[2];
         st = ($urandom % 4) != 0;
         axi_write(ba(ctl_idx[g]), d, st, `LDR_RESP_OKAY);
         if (st)
            ctl_m[g] = d & 8'h86;
         d = 8'($urandom);
         st = ($urandom % 4) != 0;
         axi_write(ba(vsel_idx[g+1]), d, st, `LDR_RESP_OKAY);
         if (st)
            vsel_m[g+1] = d[5:0];
         chk_all();
      end
      // Refused writes leave every register untouched.
      axi_write(ba(`LDR_IDX_NONE), 8'hFF, 1'h1, `LDR_RESP_DECERR);
      axi_write(ba(8'h81), 8'hFF, 1'h1, `LDR_RESP_DECERR);
      axi_write(ba(8'h58), 8'hFF, 1'h1, `LDR_RESP_DECERR);
      axi_write(ba(`LDR_IDX_B_VSEL) | 12'h001, 8'hFF, 1'h1,
                `LDR_RESP_DECERR);
      chk_all();
      // A second reset in mid-run clears every field.
      do_reset();
      chk_all();
      final_report();
   end

   // Watchdog: the whole sequence takes under two thousand cycles.
   initial begin
      repeat (30000) @(posedge aclk);
      fail_count++;
      final_report();
   end

endmodule
